// ---- rtl/fic_cfg_defaults.sv ----
`timescale 1ns/1ps
module fic_cfg_defaults
    import fic_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       rst_n,
    input  wire logic       sck,
    input  wire logic       cs_n,
    input  wire logic [3:0] sio_in,
    output logic      [3:0] sio_out,
    output logic      [3:0] sio_oe,
    output logic            addrLen4,
    output logic            fourWireMode,
    output logic            io3ResetEn,
    output logic      [3:0] readDummy,
    output logic            quadWidthDefault,
    output logic            progBusy
);

    // System-domain state
    logic [7:0]  nvReg;
    logic [7:0]  pendNv;
    logic [7:0]  runtime;
    logic        quadNv;
    logic [7:0]  progCnt;
    logic        togSeen;
    logic        pendEvt;
    logic [2:0]  syncOut;
    logic        csHighS;
    logic        togS;
    logic        io3S;
    logic        evtNew;
    logic        commit;
    logic        hwReset;
    logic        swReset;
    logic        progStart;
    logic        rtWrite;
    logic        cfg1Write;

    // Link-domain state
    logic        frameClr;
    fic_phase_t  phase;
    logic [5:0]  cnt;
    logic [31:0] sh;
    logic [31:0] shNext;
    logic [5:0]  cntNext;
    logic [5:0]  addrBits;
    logic [7:0]  cmd;
    logic [23:0] capAddr;
    logic [7:0]  capData;
    fic_kind_t   capKind;
    logic        evtTog;
    logic [7:0]  rdByte;
    logic [7:0]  rdSel;
    logic [7:0]  outSh;
    logic        outStarted;

    function automatic logic [7:0] otpMerge(input logic [7:0] cur, input logic [7:0] wr);
        logic [7:0] moved;
        moved = (cur ^ NV_DEFAULT) | (wr ^ NV_DEFAULT);
        return (NV_DEFAULT ^ moved) & NV_WRITABLE_MASK;
    endfunction : otpMerge

    assign addrLen4         = runtime[ADDR_LEN_BIT];
    assign fourWireMode     = runtime[FOUR_WIRE_BIT];
    assign io3ResetEn       = runtime[IO3_RESET_BIT];
    assign readDummy        = runtime[DUMMY_LSB +: 4];
    assign quadWidthDefault = quadNv;

    // ---------------- Link domain (SPI mode 0) ----------------

    // Frame state clears whenever the host deselects; sck stops between frames
    assign frameClr = cs_n | ~rst_n;

    always_comb
    begin
        shNext   = fourWireMode ? {sh[27:0], sio_in} : {sh[30:0], sio_in[0]};
        cntNext  = cnt + (fourWireMode ? 6'h04 : 6'h01);
        addrBits = addrLen4 ? 6'h20 : 6'h18;
    end

    // Top address byte never takes part in decode
    always_comb
    begin
        rdSel = 8'h00;
        if (shNext[23:0] == DEFAULTS_NV_ADDR)
            rdSel = nvReg;
        else if (shNext[23:0] == CONTROLS_RT_ADDR)
            rdSel = runtime;
        else if (shNext[23:0] == STATUS1_ADDR)
            rdSel = {7'h00, progBusy};
        else if (shNext[23:0] == CONFIG1_NV_ADDR)
            rdSel = {6'h00, quadNv, 1'b0};
    end

    always_ff @(posedge sck or posedge frameClr)
    begin
        if (frameClr)
        begin
            phase <= PH_CMD;
            cnt   <= 6'h00;
            sh    <= 32'h0000_0000;
        end
        else
        begin
            sh  <= shNext;
            cnt <= cntNext;
            unique case (phase)
                PH_CMD:
                begin
                    if (cntNext == 6'h08)
                    begin
                        cnt <= 6'h00;
                        if (shNext[7:0] == GENERIC_REG_READ_CMD
                            || shNext[7:0] == GENERIC_REG_WRITE_CMD)
                            phase <= PH_ADDR;
                        else
                            phase <= PH_IGNORE;
                    end
                end
                PH_ADDR:
                begin
                    if (cntNext == addrBits)
                    begin
                        cnt <= 6'h00;
                        if (cmd == GENERIC_REG_WRITE_CMD)
                            phase <= PH_DATA_IN;
                        else if (readDummy == 4'h0)
                            phase <= PH_DATA_OUT;
                        else
                            phase <= PH_DUMMY;
                    end
                end
                PH_DUMMY:
                begin
                    // Dummy length counts clocks, not bits
                    cnt <= cnt + 6'h01;
                    if (cnt + 6'h01 == {2'h0, readDummy})
                    begin
                        cnt   <= 6'h00;
                        phase <= PH_DATA_OUT;
                    end
                end
                PH_DATA_IN:
                begin
                    if (cntNext == 6'h08)
                        phase <= PH_IGNORE;
                end
                PH_DATA_OUT,
                PH_IGNORE:
                    cnt <= cnt;
            endcase
        end
    end

    // Captured fields outlive the frame so the system side can read them later
    always_ff @(posedge sck or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cmd     <= 8'h00;
            capAddr <= 24'h00_0000;
            capData <= 8'h00;
            capKind <= K_NONE;
            evtTog  <= 1'b0;
            rdByte  <= 8'h00;
        end
        else if (!cs_n)
        begin
            if (phase == PH_CMD && cntNext == 6'h08)
            begin
                cmd     <= shNext[7:0];
                capKind <= K_NONE;
                if (shNext[7:0] == SOFT_RESET_CMD)
                begin
                    capKind <= K_SWRST;
                    evtTog  <= ~evtTog;
                end
            end
            if (phase == PH_ADDR && cntNext == addrBits)
            begin
                capAddr <= shNext[23:0];
                rdByte  <= rdSel;
            end
            if (phase == PH_DATA_IN && cntNext == 6'h08)
            begin
                capData <= shNext[7:0];
                capKind <= K_WRITE;
                evtTog  <= ~evtTog;
            end
        end
    end

    // Read data launched on falling edges; the byte repeats if the host keeps clocking
    always_ff @(negedge sck or posedge frameClr)
    begin
        if (frameClr)
        begin
            sio_out    <= 4'h0;
            sio_oe     <= 4'h0;
            outSh      <= 8'h00;
            outStarted <= 1'b0;
        end
        else if (phase == PH_DATA_OUT)
        begin
            outStarted <= 1'b1;
            if (fourWireMode)
            begin
                sio_out <= outStarted ? outSh[7:4] : rdByte[7:4];
                outSh   <= outStarted ? {outSh[3:0], outSh[7:4]} : {rdByte[3:0], rdByte[7:4]};
                sio_oe  <= 4'hF;
            end
            else
            begin
                sio_out <= {2'h0, (outStarted ? outSh[7] : rdByte[7]), 1'b0};
                outSh   <= outStarted ? {outSh[6:0], outSh[7]} : {rdByte[6:0], rdByte[7]};
                sio_oe  <= 4'h2;
            end
        end
    end

    // ---------------- System domain ----------------

    fic_sync #(
        .WIDTH (3),
        .INIT  (3'h5)
    ) u_sync (
        .clk   (sys_clk),
        .rst_n (rst_n),
        .din   ({sio_in[3], evtTog, cs_n}),
        .dout  (syncOut)
    );

    assign csHighS = syncOut[0];
    assign togS    = syncOut[1];
    assign io3S    = syncOut[2];
    assign evtNew  = togS ^ togSeen;

    // Captured fields are stable here: sck has stopped once the host deselects
    assign commit    = pendEvt & csHighS;
    assign swReset   = commit & (capKind == K_SWRST);
    assign hwReset   = io3ResetEn & csHighS & ~io3S;
    assign rtWrite   = commit & (capKind == K_WRITE) & (capAddr == CONTROLS_RT_ADDR);
    assign cfg1Write = commit & (capKind == K_WRITE) & (capAddr == CONFIG1_NV_ADDR)
                       & ~progBusy;
    assign progStart = commit & (capKind == K_WRITE) & (capAddr == DEFAULTS_NV_ADDR)
                       & ~progBusy;

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            togSeen <= 1'b0;
            pendEvt <= 1'b0;
        end
        else
        begin
            togSeen <= togS;
            // A new event wins over the commit that retires the previous one
            if (evtNew)
                pendEvt <= 1'b1;
            else if (commit)
                pendEvt <= 1'b0;
        end
    end

    // Runtime controls; the reset constant equals the shipped non-volatile byte
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            runtime <= NV_DEFAULT;
        else if (hwReset || swReset)
            runtime <= nvReg;
        else if (rtWrite)
            runtime <= capData & NV_WRITABLE_MASK;
    end

    // Non-volatile byte models a fresh part at power-on; writes ignored while busy
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            nvReg    <= NV_DEFAULT;
            pendNv   <= NV_DEFAULT;
            progBusy <= 1'b0;
            progCnt  <= 8'h00;
        end
        else if (progStart)
        begin
            pendNv   <= otpMerge(nvReg, capData);
            progBusy <= 1'b1;
            progCnt  <= PROG_CYCLES - 8'h01;
        end
        else if (progBusy)
        begin
            if (progCnt == 8'h00)
            begin
                nvReg    <= pendNv;
                progBusy <= 1'b0;
            end
            else
                progCnt <= progCnt - 8'h01;
        end
    end

    // Quad default may not drop while four-wire is selected
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            quadNv <= 1'b0;
        else if (progBusy && progCnt == 8'h00 && pendNv[FOUR_WIRE_BIT])
            quadNv <= 1'b1;
        else if (cfg1Write && !(fourWireMode || nvReg[FOUR_WIRE_BIT]))
            quadNv <= capData[QUAD_BIT];
    end

    // ---------------- Checks ----------------

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);

    otp_one_way_a: assert property (
        ((($past(nvReg) ^ NV_DEFAULT) & ~(nvReg ^ NV_DEFAULT)) == 8'h00))
    else $error("Programmed non-volatile bit returned to its default");

    four_wire_nv_a: assert property (!$fell(nvReg[FOUR_WIRE_BIT]))
    else $error("Non-volatile four-wire bit was cleared");

    latency_msb_a: assert property (!$rose(nvReg[DUMMY_LSB + 3]))
    else $error("Latency top bit returned to 1");

    quad_follows_a: assert property (
        $rose(nvReg[FOUR_WIRE_BIT]) |-> quadNv)
    else $error("Quad default not set with four-wire default");

    soft_reload_a: assert property (
        swReset && !rtWrite |=> runtime == $past(nvReg))
    else $error("Software reset did not reload runtime controls");

    io3_reset_a: assert property (
        hwReset |=> runtime == $past(nvReg))
    else $error("IO3 reset did not reload runtime controls");

    rt_switch_a: assert property (
        rtWrite && !hwReset |=> fourWireMode == $past(capData[FOUR_WIRE_BIT]))
    else $error("Runtime four-wire write not applied at once");

    prog_busy_a: assert property (
        progStart |=> progBusy [*8])
    else $error("Busy did not cover programming");

    prog_done_a: assert property (
        progStart |-> ##[1:200] !progBusy)
    else $error("Programming never finished");

endmodule : fic_cfg_defaults

// ---- rtl/fic_pkg.sv ----
// Notes on behaviour
// - Runtime controls reload from the non-volatile byte at power-on, hardware and software reset.
// - Each programmable non-volatile bit leaves its shipped value once, never returns.
// - Address-length default 0 gives 3-byte addressing, 1 gives 4-byte addressing.
// - Address length applies to addressed commands not fixed at 3 or 4 bytes.
// - The small-density part takes 4-byte addresses and ignores the top byte.
// - Instruction-width default 0 means serial instruction, 1 means four-wire everything.
// - Programming the non-volatile four-wire bit also programs the quad width default.
// - Setting the runtime four-wire bit takes effect before the next command.
// - Non-volatile programming shows busy in status; host polls until it clears.
// - Clearing the runtime four-wire bit returns the interface to serial instructions.
// - A programmed non-volatile four-wire bit is never cleared again.
// - With IO3 reset enabled, IO3 low outside transfers acts as hardware reset.
// - Read latency field inserts 0 to 15 dummy cycles before read data.
// - Latency top bit ships 1, may go to 0 once; lower bits ship 0.
// - Variable latency covers the fast reads and the generic register read.
// - Generic register read is command 65h, generic register write is 71h.
package fic_pkg;

    localparam logic [7:0]  GENERIC_REG_READ_CMD  = 8'h65;
    localparam logic [7:0]  GENERIC_REG_WRITE_CMD = 8'h71;
    localparam logic [7:0]  SOFT_RESET_CMD        = 8'hF0;

    localparam logic [23:0] STATUS1_ADDR          = 24'h80_0000;
    localparam logic [23:0] CONFIG1_NV_ADDR       = 24'h00_0002;
    localparam logic [23:0] DEFAULTS_NV_ADDR      = 24'h00_0003;
    localparam logic [23:0] CONTROLS_RT_ADDR      = 24'h80_0003;

    localparam logic [7:0]  NV_DEFAULT            = 8'h08;
    localparam logic [7:0]  NV_WRITABLE_MASK      = 8'hEF;
    localparam int          ADDR_LEN_BIT          = 7;
    localparam int          FOUR_WIRE_BIT         = 6;
    localparam int          IO3_RESET_BIT         = 5;
    localparam int          DUMMY_LSB             = 0;
    localparam int          BUSY_BIT              = 0;
    localparam int          QUAD_BIT              = 1;

    localparam int          SYS_CLK_NS            = 8;
    localparam int          PROG_TIME_NS          = 1000;
    localparam logic [7:0]  PROG_CYCLES           =
        8'((PROG_TIME_NS + SYS_CLK_NS - 1) / SYS_CLK_NS);

    typedef enum {PH_CMD, PH_ADDR, PH_DUMMY, PH_DATA_IN, PH_DATA_OUT, PH_IGNORE} fic_phase_t;
    typedef enum {K_NONE, K_WRITE, K_SWRST} fic_kind_t;

endpackage : fic_pkg

// ---- rtl/fic_sync.sv ----
`timescale 1ns/1ps
module fic_sync
#(
    parameter int         WIDTH = 3,
    parameter logic [2:0] INIT  = 3'h0
)
(
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] din,
    output logic      [WIDTH-1:0] dout
);

    logic [WIDTH-1:0] stage1;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            stage1 <= INIT[WIDTH-1:0];
            dout   <= INIT[WIDTH-1:0];
        end
        else
        begin
            stage1 <= din;
            dout   <= stage1;
        end
    end

endmodule : fic_sync

// ---- sim/fic_cfg_defaults_tb_top.sv ----
`timescale 1ns/1ps
module fic_cfg_defaults_tb_top
    import fic_pkg::*;
();
    logic       sys_clk = 1'b0;
    logic       rst_n   = 1'b0;
    logic       sck;
    logic       cs_n;
    logic [3:0] sioDrive;
    logic [3:0] sioOut;
    logic [3:0] sioOe;
    wire  [3:0] sioWire;
    logic       addrLen4;
    logic       fourWireMode;
    logic       io3ResetEn;
    logic [3:0] readDummy;
    logic       quadWidthDefault;
    logic       progBusy;
    wire  [7:0] ctl;
    int         nFail      = 0;
    int         checksDone = 0;
    int         cycles     = 0;
    logic [7:0] v;
    int         n;

    assign sioWire = (sioOe & sioOut) | (~sioOe & sioDrive);
    assign ctl = {addrLen4, fourWireMode, io3ResetEn, quadWidthDefault, readDummy};

    always #4 sys_clk = ~sys_clk;

    fic_cfg_defaults DUT (
        .sys_clk          (sys_clk),
        .rst_n            (rst_n),
        .sck              (sck),
        .cs_n             (cs_n),
        .sio_in           (sioWire),
        .sio_out          (sioOut),
        .sio_oe           (sioOe),
        .addrLen4         (addrLen4),
        .fourWireMode     (fourWireMode),
        .io3ResetEn       (io3ResetEn),
        .readDummy        (readDummy),
        .quadWidthDefault (quadWidthDefault),
        .progBusy         (progBusy)
    );

    fic_host_model host (
        .sck      (sck),
        .cs_n     (cs_n),
        .sioDrive (sioDrive),
        .sioWire  (sioWire)
    );

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checksDone++;
        if (seen !== exp)
        begin
            nFail++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic rd_chk(input string what, input logic [31:0] a, input logic [7:0] exp);
        logic [7:0] r;
        host.reg_read(a, r);
        check(what, r, exp);
    endtask : rd_chk

    task automatic mode(input logic w, input logic a4, input int d);
        host.wide = w;
        host.addr4 = a4;
        host.dummy = d;
    endtask : mode

    // Host waits on busy rather than a fixed time
    task automatic poll_busy(input logic expBusy);
        n = 0;
        do
        begin
            host.reg_read(STATUS1_ADDR, v);
            if (n == 0 && expBusy)
                check("busyFirst", v & 8'h01, 8'h01);
            n++;
        end while (v[BUSY_BIT] !== 1'b0 && n < 20);
        check("busyEnd", v & 8'h01, 8'h00);
    endtask : poll_busy

    task automatic giveVerdict;
        $display("Checks %0d mismatches %0d", checksDone, nFail);
        if (nFail == 0 && checksDone > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : giveVerdict

    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 8000)
        begin
            nFail++;
            giveVerdict;
        end
    end

    initial
    begin
        repeat (16) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge sys_clk);
        check("ctlReset", ctl, 8'h08);
        rd_chk("rtReset", CONTROLS_RT_ADDR, 8'h08);
        rd_chk("nvReset", DEFAULTS_NV_ADDR, 8'h08);
        rd_chk("status", STATUS1_ADDR, 8'h00);
        check("oeIdle", {4'h0, sioOe}, 8'h00);
        check("outIdle", {4'h0, sioOut}, 8'h00);
        rd_chk("unmapped", 32'h0000_0010, 8'h00);
        host.reg_write(CONTROLS_RT_ADDR, 8'h00);
        check("ctlDummy0", ctl, 8'h00);
        mode(1'b0, 1'b0, 0);
        rd_chk("rtDummy0", CONTROLS_RT_ADDR, 8'h00);
        host.reg_write(CONTROLS_RT_ADDR, 8'hFF);
        check("ctlAll", ctl, 8'hEF);
        mode(1'b1, 1'b1, 15);
        rd_chk("rtWide", {8'hA5, CONTROLS_RT_ADDR}, 8'hEF);
        host.reg_write({8'h5A, CONTROLS_RT_ADDR}, 8'h08);
        check("ctlSerial", ctl, 8'h08);
        mode(1'b0, 1'b0, 8);
        rd_chk("rtSerial", CONTROLS_RT_ADDR, 8'h08);
        // Quad default is free to move while no four-wire selection exists
        host.reg_write(CONFIG1_NV_ADDR, 8'h02);
        rd_chk("cfg1Set", CONFIG1_NV_ADDR, 8'h02);
        host.reg_write(CONFIG1_NV_ADDR, 8'h00);
        check("ctlQuadClr", ctl, 8'h08);
        host.reg_write(DEFAULTS_NV_ADDR, 8'hC4);
        check("busyNow", {7'h00, progBusy}, 8'h01);
        // Second programming request lands while busy and must be dropped
        host.reg_write(DEFAULTS_NV_ADDR, 8'h2C);
        poll_busy(1'b1);
        check("ctlAfterNv", ctl, 8'h18);
        rd_chk("nvProg", DEFAULTS_NV_ADDR, 8'hC4);
        host.reg_write(DEFAULTS_NV_ADDR, 8'h08);
        poll_busy(1'b0);
        rd_chk("nvKeep", DEFAULTS_NV_ADDR, 8'hC4);
        host.soft_reset;
        check("ctlSoft", ctl, 8'hD4);
        mode(1'b1, 1'b1, 4);
        rd_chk("rtSoft", CONTROLS_RT_ADDR, 8'hC4);
        host.reg_write(CONTROLS_RT_ADDR, 8'hE0);
        check("ctlIo3", ctl, 8'hF0);
        host.io3_pull;
        check("ctlIo3Rst", ctl, 8'hD4);
        host.reg_write(CONFIG1_NV_ADDR, 8'h00);
        rd_chk("cfg1Keep", CONFIG1_NV_ADDR, 8'h02);
        @(posedge sys_clk);
        rst_n <= 1'b0;
        repeat (4) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge sys_clk);
        check("ctlHw", ctl, 8'h08);
        mode(1'b0, 1'b0, 8);
        rd_chk("nvHw", DEFAULTS_NV_ADDR, 8'h08);
        giveVerdict;
    end
endmodule : fic_cfg_defaults_tb_top

// ---- sim/fic_host_model.sv ----
`timescale 1ns/1ps
module fic_host_model
    import fic_pkg::*;
(
    output logic            sck,
    output logic            cs_n,
    output logic      [3:0] sioDrive,
    input  wire logic [3:0] sioWire
);
    logic wide  = 1'b0;
    logic addr4 = 1'b0;
    int   dummy = 8;
    logic idle  = 1'b0;

    initial
    begin
        sck = 1'b0;
        cs_n = 1'b1;
        sioDrive = 4'hF;
    end

    // Released lines toggle so a stale level never reads as data
    task automatic tick(output logic [3:0] smp);
        if (idle)
            sioDrive = ~sioDrive;
        #3 sck = 1'b1;
        smp = sioWire;
        #3 sck = 1'b0;
    endtask : tick

    task automatic send(input logic [31:0] val, input int nbits);
        logic [3:0] smp;
        for (int i = nbits; i > 0; i = i - (wide ? 4 : 1))
        begin
            sioDrive = wide ? val[i-1 -: 4] : {3'b111, val[i-1]};
            tick(smp);
        end
    endtask : send

    task automatic start(input logic [7:0] cmd);
        #1.7 cs_n = 1'b0;
        #3;
        send({24'h00_0000, cmd}, 8);
    endtask : start

    // IO3 back high before deselect, else it would act as reset
    task automatic finish;
        idle = 1'b0;
        sioDrive = 4'hF;
        #3 cs_n = 1'b1;
        #80;
    endtask : finish

    task automatic reg_write(input logic [31:0] addr, input logic [7:0] data);
        start(GENERIC_REG_WRITE_CMD);
        send(addr, addr4 ? 32 : 24);
        send({24'h00_0000, data}, 8);
        finish;
    endtask : reg_write

    task automatic reg_read(input logic [31:0] addr, output logic [7:0] rd);
        logic [3:0] smp;
        start(GENERIC_REG_READ_CMD);
        send(addr, addr4 ? 32 : 24);
        idle = 1'b1;
        repeat (dummy) tick(smp);
        repeat (wide ? 2 : 8)
        begin
            tick(smp);
            rd = wide ? {rd[3:0], smp} : {rd[6:0], smp[1]};
        end
        finish;
    endtask : reg_read

    task automatic soft_reset;
        start(SOFT_RESET_CMD);
        finish;
    endtask : soft_reset

    task automatic io3_pull;
        sioDrive[3] = 1'b0;
        #40;
        sioDrive[3] = 1'b1;
        #40;
    endtask : io3_pull
endmodule : fic_host_model
